// *** common/cms_pkg.sv ***
// Constants and types shared by the clock multiplier and system clock selector.
//
// Contract
// - Multiplier output runs at four times its input, then scaled.
// - Input select: 00 internal/2, 01 external, 10 external/2, 11 internal.
// - Scale codes 000-010 by 1, 011 2/3, 100 1/2, 101 2/5, 110 1/3, 111 2/7.
// - Scales 2/3, 2/5 and 2/7 may have unequal high and low time.
// - Control bit 7 enables the multiplier when set.
// - Initialize is zero while enabling; writing one once enabled starts initialization.
// - Read-only bit 5 shows one once the multiplier has locked.
// - Inputs below about 1.6 MHz give bursts of four fast pulses, then a gap.
// - Source select: 00 internal, 01 external, 10 multiplier, 11 real-time-clock oscillator.
// - Source may switch while running; software selects only settled sources.
// - External oscillator stays available to timers whatever source is selected.
// - Output divide: 00 undivided, 01 by 2, 10 by 4, 11 by 8.
// - Hardware sets crystal valid once the external oscillator has settled.
// - Internal oscillator may be selected right after being enabled.
// - Select register bits 7-6, 3 and reserved bit 2 read zero.
// - Crystal valid reads zero unless a crystal mode is selected.
`default_nettype none
package cms_pkg;
    // Register addresses and reset value.
    localparam logic [7:0] ADDR_SYSTEM_CLOCK_SEL = 8'ha9;
    localparam logic [7:0] ADDR_MULT_CTRL = 8'hab;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions in the multiplier control register.
    localparam int MC_ENABLE_BIT = 7;
    localparam int MC_INIT_BIT = 6;
    localparam int MC_LOCKED_BIT = 5;
    localparam int MC_SCALE_MSB = 4;
    localparam int MC_SCALE_LSB = 2;
    localparam int MC_SEL_MSB = 1;
    localparam int MC_SEL_LSB = 0;
    localparam logic [7:0] MC_STORE_MASK = 8'h9f;
    // Field positions in the system clock select register.
    localparam int SC_DIV_MSB = 5;
    localparam int SC_DIV_LSB = 4;
    localparam int SC_SRC_MSB = 1;
    localparam int SC_SRC_LSB = 0;
    localparam logic [7:0] SC_STORE_MASK = 8'h33;
    // Oscillator pin indices in the synchroniser bank.
    localparam int OSC_INT = 0;
    localparam int OSC_EXT = 1;
    localparam int OSC_RTC = 2;
    localparam int OSC_SETTLED = 3;
    localparam int OSC_PINS = 4;
    // External oscillator mode bits 2:1 equal to this mean a crystal mode.
    localparam logic [1:0] XOSC_CRYSTAL = 2'h3;
    // Multiplier timing.
    localparam int MULT_FACTOR = 4;
    localparam int HALF_TICKS = 2 * MULT_FACTOR;
    localparam int TICK_SHIFT = $clog2(HALF_TICKS);
    localparam logic [2:0] SCALE_MIN_N = 3'h2;
    localparam int PERIOD_W = 16;
    localparam int LOCK_EDGES = 4;
    localparam real CLOCK_MHZ = 125.0;
    localparam real MIN_MULT_INPUT_FREQ_MHZ = 1.6;
    localparam int BURST_SPACING_CYC = int'($floor(CLOCK_MHZ / (MIN_MULT_INPUT_FREQ_MHZ * HALF_TICKS)));
    // Encodings.
    typedef enum logic [1:0] {MSEL_INT_HALF, MSEL_EXT, MSEL_EXT_HALF, MSEL_INT} cms_mult_in_t;
    typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_MULT, SRC_RTC} cms_src_t;
    typedef enum logic [1:0] {LK_IDLE, LK_LOCKING, LK_LOCKED} cms_lock_state_t;
    typedef enum logic [1:0] {SW_RUN, SW_WAIT_OLD, SW_WAIT_NEW} cms_sw_state_t;
endpackage : cms_pkg
`default_nettype wire

// *** common/cms_sw_if.sv ***
// Interface between the controller and the glitch-free source switch.
`timescale 1ns/10ps
`default_nettype none
interface cms_sw_if;
    logic [3:0] src;
    logic [1:0] sel_req;
    logic clk_out;
    logic busy;
    modport ctrl (output src, output sel_req, input clk_out, input busy);
    modport sw (input src, input sel_req, output clk_out, output busy);
endinterface : cms_sw_if
`default_nettype wire

// *** logic/cms_clock_switch.sv ***
// Glitch-free system clock source switch.
`timescale 1ns/10ps
`default_nettype none
module cms_clock_switch (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Controller side.
    cms_sw_if.sw sw
);
    import cms_pkg::*;

    cms_sw_state_t state_reg;
    logic [1:0] act_reg;
    logic [1:0] pend_reg;
    logic out_reg;

    // The old source is left only in its low phase and the new one is joined only in
    // its low phase, so no shortened high pulse reaches the system clock.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_reg <= SW_RUN;
            act_reg <= SRC_INT;
            pend_reg <= SRC_INT;
            out_reg <= 1'b0;
        end else begin
            case (state_reg)
                SW_RUN: begin
                    out_reg <= sw.src[act_reg];
                    if (sw.sel_req != act_reg) begin
                        pend_reg <= sw.sel_req;
                        state_reg <= SW_WAIT_OLD;
                    end
                end
                SW_WAIT_OLD: begin
                    out_reg <= sw.src[act_reg];
                    if (!sw.src[act_reg]) begin
                        out_reg <= 1'b0;
                        state_reg <= SW_WAIT_NEW;
                    end
                end
                default: begin
                    out_reg <= 1'b0;
                    if (!sw.src[pend_reg]) begin
                        act_reg <= pend_reg;
                        state_reg <= SW_RUN;
                    end
                end
            endcase
        end
    end

    assign sw.clk_out = out_reg;
    assign sw.busy = (state_reg != SW_RUN);

    a_switch_follow: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state_reg == SW_RUN && sw.sel_req == act_reg) |=> out_reg == $past(sw.src[act_reg]))
        else $error("System clock does not follow the active source.");
    a_switch_gap: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state_reg == SW_WAIT_NEW) |=> !out_reg)
        else $error("System clock high while waiting for the new source.");
    c_switch_done: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        state_reg == SW_WAIT_NEW ##1 state_reg == SW_RUN);
endmodule : cms_clock_switch
`default_nettype wire

// *** logic/cms_clock_ctrl.sv ***
// Clock multiplier, system clock selection and clock output divider.
`timescale 1ns/10ps
`default_nettype none
module cms_clock_ctrl (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Special-function register port.
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    output logic [7:0] sfr_rdata_o,
    // Oscillator pins and external oscillator status.
    input wire logic int_osc_i,
    input wire logic ext_osc_i,
    input wire logic rtc_osc_i,
    input wire logic ext_osc_settled_i,
    input wire logic [2:0] ext_osc_mode_i,
    // Clock outputs.
    output logic system_clock_o,
    output logic clock_out_pin_o,
    output logic ext_timer_clk_o,
    output logic mult_clock_o,
    // Status outputs.
    output logic crystal_valid_o,
    output logic mult_locked_o
);
    import cms_pkg::*;

    logic [OSC_PINS-1:0] osc_meta_reg;
    logic [OSC_PINS-1:0] osc_sync_reg;
    logic [OSC_PINS-1:0] osc_prev_reg;
    logic [OSC_PINS-1:0] osc_rise;
    logic [7:0] system_clock_sel_reg;
    logic [7:0] mult_ctrl_reg;
    logic [7:0] rdata_reg;
    logic int_half_reg;
    logic ext_half_reg;
    logic mult_in;
    logic mult_in_prev_reg;
    logic in_rise;
    logic mult_enable;
    logic init_write;
    cms_lock_state_t lock_state_reg;
    logic [2:0] lock_cnt_reg;
    logic locked_reg;
    logic [PERIOD_W-1:0] period_cnt_reg;
    logic [PERIOD_W-1:0] period_reg;
    logic [PERIOD_W-1:0] spacing;
    logic [PERIOD_W-1:0] space_cnt_reg;
    logic [3:0] ticks_left_reg;
    logic half_tick_reg;
    logic [2:0] scale_n;
    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    logic mult_clk_reg;
    logic sys_prev_reg;
    logic [2:0] div_cnt_reg;
    logic clk_pin_reg;
    logic ext_timer_reg;
    logic xtal_valid_reg;

    cms_sw_if sw_bus ();

    // Every oscillator pin is foreign to this clock, so each passes two flops first;
    // the edge detector compares the second stage with a third flop that delays it.
    genvar g;
    generate
        for (g = 0; g < OSC_PINS; g++) begin : g_sync
            always_ff @(posedge clock_i) begin
                if (!rst_b_i) begin
                    osc_meta_reg[g] <= 1'b0;
                    osc_sync_reg[g] <= 1'b0;
                    osc_prev_reg[g] <= 1'b0;
                end else begin
                    osc_meta_reg[g] <= (g == OSC_INT) ? int_osc_i :
                                       (g == OSC_EXT) ? ext_osc_i :
                                       (g == OSC_RTC) ? rtc_osc_i : ext_osc_settled_i;
                    osc_sync_reg[g] <= osc_meta_reg[g];
                    osc_prev_reg[g] <= osc_sync_reg[g];
                end
            end
            assign osc_rise[g] = osc_sync_reg[g] & ~osc_prev_reg[g];
        end
    endgenerate

    // Software write decoding.
    assign mult_enable = mult_ctrl_reg[MC_ENABLE_BIT];
    assign init_write = sfr_wr_i && (sfr_addr_i == ADDR_MULT_CTRL) && sfr_wdata_i[MC_INIT_BIT];

    // Clock select register; unused and reserved bits are never stored.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            system_clock_sel_reg <= REG_RESET;
        end else if (sfr_wr_i && sfr_addr_i == ADDR_SYSTEM_CLOCK_SEL) begin
            system_clock_sel_reg <= sfr_wdata_i & SC_STORE_MASK;
        end
    end

    // Multiplier control register. Initialize is only accepted when the multiplier
    // was already enabled before this write, so a single write of enable and
    // initialize together leaves initialize clear.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            mult_ctrl_reg <= REG_RESET;
        end else if (sfr_wr_i && sfr_addr_i == ADDR_MULT_CTRL) begin
            mult_ctrl_reg <= sfr_wdata_i & MC_STORE_MASK;
            mult_ctrl_reg[MC_INIT_BIT] <= sfr_wdata_i[MC_INIT_BIT] & mult_enable
                & sfr_wdata_i[MC_ENABLE_BIT];
        end
    end

    // Read data is registered; it shows the addressed register one cycle later.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rdata_reg <= REG_RESET;
        end else if (sfr_addr_i == ADDR_SYSTEM_CLOCK_SEL) begin
            rdata_reg <= system_clock_sel_reg & SC_STORE_MASK;
        end else if (sfr_addr_i == ADDR_MULT_CTRL) begin
            rdata_reg <= {mult_ctrl_reg[MC_ENABLE_BIT:MC_INIT_BIT], locked_reg,
                mult_ctrl_reg[MC_SCALE_MSB:MC_SEL_LSB]};
        end else begin
            rdata_reg <= REG_RESET;
        end
    end

    // Halved copies of the internal and external oscillators.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            int_half_reg <= 1'b0;
            ext_half_reg <= 1'b0;
        end else begin
            int_half_reg <= int_half_reg ^ osc_rise[OSC_INT];
            ext_half_reg <= ext_half_reg ^ osc_rise[OSC_EXT];
        end
    end

    // Multiplier input selection.
    always_comb begin
        case (cms_mult_in_t'(mult_ctrl_reg[MC_SEL_MSB:MC_SEL_LSB]))
            MSEL_INT_HALF: mult_in = int_half_reg;
            MSEL_EXT: mult_in = osc_sync_reg[OSC_EXT];
            MSEL_EXT_HALF: mult_in = ext_half_reg;
            default: mult_in = osc_sync_reg[OSC_INT];
        endcase
    end

    // Rising edges of the selected multiplier input.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            mult_in_prev_reg <= 1'b0;
        end else begin
            mult_in_prev_reg <= mult_in;
        end
    end
    assign in_rise = mult_in & ~mult_in_prev_reg;

    // Lock sequencer: initialization runs for a fixed count of input edges before
    // ready is shown. Dropping enable returns to idle at once.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            lock_state_reg <= LK_IDLE;
            lock_cnt_reg <= 3'h0;
            locked_reg <= 1'b0;
        end else if (!mult_enable) begin
            lock_state_reg <= LK_IDLE;
            lock_cnt_reg <= 3'h0;
            locked_reg <= 1'b0;
        end else begin
            case (lock_state_reg)
                LK_IDLE: begin
                    locked_reg <= 1'b0;
                    if (init_write && sfr_wdata_i[MC_ENABLE_BIT]) begin
                        lock_state_reg <= LK_LOCKING;
                        lock_cnt_reg <= 3'h0;
                    end
                end
                LK_LOCKING: begin
                    if (in_rise) begin
                        lock_cnt_reg <= lock_cnt_reg + 3'h1;
                        if (lock_cnt_reg == 3'(LOCK_EDGES - 1)) begin
                            lock_state_reg <= LK_LOCKED;
                            locked_reg <= 1'b1;
                        end
                    end
                end
                default: begin
                    locked_reg <= 1'b1;
                    if (init_write) begin
                        lock_state_reg <= LK_LOCKING;
                        lock_cnt_reg <= 3'h0;
                        locked_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Input period measurement in system cycles, saturating for very slow inputs.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            period_cnt_reg <= '0;
            period_reg <= '0;
        end else if (in_rise) begin
            period_reg <= period_cnt_reg;
            period_cnt_reg <= PERIOD_W'(1);
        end else if (period_cnt_reg != '1) begin
            period_cnt_reg <= period_cnt_reg + PERIOD_W'(1);
        end
    end

    // Half-tick spacing: an eighth of the input period, never slower than the
    // spacing for the minimum input frequency. A slow input therefore gives a fast
    // burst and then waits for its next edge.
    always_comb begin
        spacing = period_reg >> TICK_SHIFT;
        if (spacing > PERIOD_W'(BURST_SPACING_CYC)) begin
            spacing = PERIOD_W'(BURST_SPACING_CYC);
        end
        if (spacing == '0) begin
            spacing = PERIOD_W'(1);
        end
    end

    // Half-tick generator: eight half ticks per input edge, four output periods at scale 1.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ticks_left_reg <= 4'h0;
            space_cnt_reg <= '0;
            half_tick_reg <= 1'b0;
        end else if (!mult_enable) begin
            ticks_left_reg <= 4'h0;
            space_cnt_reg <= '0;
            half_tick_reg <= 1'b0;
        end else if (in_rise) begin
            ticks_left_reg <= 4'(HALF_TICKS - 1);
            space_cnt_reg <= spacing;
            half_tick_reg <= 1'b1;
        end else if (ticks_left_reg != 4'h0 && space_cnt_reg <= PERIOD_W'(1)) begin
            ticks_left_reg <= ticks_left_reg - 4'h1;
            space_cnt_reg <= spacing;
            half_tick_reg <= 1'b1;
        end else begin
            if (ticks_left_reg != 4'h0) begin
                space_cnt_reg <= space_cnt_reg - PERIOD_W'(1);
            end
            half_tick_reg <= 1'b0;
        end
    end

    // Scaling: the output period spans N half ticks, N being the scale code with a
    // floor of two. Odd N gives the shorter high time.
    assign scale_n = (mult_ctrl_reg[MC_SCALE_MSB:MC_SCALE_LSB] < SCALE_MIN_N) ?
        SCALE_MIN_N : mult_ctrl_reg[MC_SCALE_MSB:MC_SCALE_LSB];
    assign phase_next = (phase_reg >= scale_n - 3'h1) ? 3'h0 : phase_reg + 3'h1;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            phase_reg <= 3'h0;
            mult_clk_reg <= 1'b0;
        end else if (!mult_enable) begin
            phase_reg <= 3'h0;
            mult_clk_reg <= 1'b0;
        end else if (half_tick_reg) begin
            phase_reg <= phase_next;
            mult_clk_reg <= (phase_next < (scale_n >> 1));
        end
    end

    // Source switch. The internal oscillator is offered with no readiness gate.
    assign sw_bus.src = {osc_sync_reg[OSC_RTC], mult_clk_reg, osc_sync_reg[OSC_EXT], osc_sync_reg[OSC_INT]};
    assign sw_bus.sel_req = system_clock_sel_reg[SC_SRC_MSB:SC_SRC_LSB];

    cms_clock_switch u_switch (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .sw(sw_bus.sw)
    );

    // Output divider counts system clock rising edges; bit k is the clock over 2^(k+1).
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            sys_prev_reg <= 1'b0;
            div_cnt_reg <= 3'h0;
            clk_pin_reg <= 1'b0;
        end else begin
            sys_prev_reg <= sw_bus.clk_out;
            if (sw_bus.clk_out && !sys_prev_reg) begin
                div_cnt_reg <= div_cnt_reg + 3'h1;
            end
            case (system_clock_sel_reg[SC_DIV_MSB:SC_DIV_LSB])
                2'h0: clk_pin_reg <= sw_bus.clk_out;
                2'h1: clk_pin_reg <= div_cnt_reg[0];
                2'h2: clk_pin_reg <= div_cnt_reg[1];
                default: clk_pin_reg <= div_cnt_reg[2];
            endcase
        end
    end

    // External oscillator to the timers and crystal valid flag.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ext_timer_reg <= 1'b0;
            xtal_valid_reg <= 1'b0;
        end else begin
            ext_timer_reg <= osc_sync_reg[OSC_EXT];
            xtal_valid_reg <= (ext_osc_mode_i[2:1] == XOSC_CRYSTAL) && osc_sync_reg[OSC_SETTLED];
        end
    end

    // Output assignments; each comes from a flop.
    assign sfr_rdata_o = rdata_reg;
    assign system_clock_o = sw_bus.clk_out;
    assign clock_out_pin_o = clk_pin_reg;
    assign ext_timer_clk_o = ext_timer_reg;
    assign mult_clock_o = mult_clk_reg;
    assign crystal_valid_o = xtal_valid_reg;
    assign mult_locked_o = locked_reg;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    a_lock_clears: assert property (
        !mult_enable |=> !mult_locked_o ##1 !mult_locked_o || mult_enable)
        else $error("Ready stayed set with the multiplier disabled.");
    a_init_gated: assert property (
        (lock_state_reg == LK_IDLE && !mult_enable) |=> lock_state_reg == LK_IDLE)
        else $error("Initialization started while disabled.");
    a_lock_cause: assert property (
        $rose(mult_locked_o) |-> $past(lock_state_reg == LK_LOCKING) && $past(in_rise))
        else $error("Ready rose without completing initialization.");
    a_burst_start: assert property (
        (in_rise && mult_enable) |=> half_tick_reg && ticks_left_reg == 4'(HALF_TICKS - 1))
        else $error("Input edge did not start a burst of half ticks.");
    a_spacing_cap: assert property (
        spacing <= PERIOD_W'(BURST_SPACING_CYC) && spacing != '0)
        else $error("Half-tick spacing outside its bounds.");
    a_phase_range: assert property (
        mult_enable |-> phase_reg < scale_n || $changed(scale_n) || $past(!mult_enable))
        else $error("Scaler phase beyond the selected divisor.");
    a_sel_reserved: assert property (
        (sfr_addr_i == ADDR_SYSTEM_CLOCK_SEL) |=> (sfr_rdata_o & ~SC_STORE_MASK) == 8'h00)
        else $error("Unused or reserved select bits read nonzero.");
    a_xtal_mode: assert property (
        crystal_valid_o |-> $past(ext_osc_mode_i[2:1] == XOSC_CRYSTAL))
        else $error("Crystal valid set outside crystal mode.");
    a_div_bypass: assert property (
        (system_clock_sel_reg[SC_DIV_MSB:SC_DIV_LSB] == 2'h0) |=> clock_out_pin_o == $past(sw_bus.clk_out))
        else $error("Undivided clock output does not follow the system clock.");
    a_timer_ext: assert property (
        ##1 ext_timer_clk_o == $past(osc_sync_reg[OSC_EXT], 1))
        else $error("Timer clock lost the external oscillator.");

    c_locked: cover property ($rose(mult_locked_o));
    c_to_mult: cover property (system_clock_o && !sw_bus.busy
        && system_clock_sel_reg[SC_SRC_MSB:SC_SRC_LSB] == SRC_MULT);
    c_scale_27: cover property (mult_ctrl_reg[MC_SCALE_MSB:MC_SCALE_LSB] == 3'h7 && $rose(mult_clock_o));
    c_xtal: cover property ($rose(crystal_valid_o));
endmodule : cms_clock_ctrl
`default_nettype wire

// *** verif/clock_multiplier_system_clock_select_tb.sv ***
// Self-checking bench for the clock multiplier and system clock selector.
`timescale 1ns/10ps
`default_nettype none
module clock_multiplier_system_clock_select_tb;
    import cms_pkg::*;
    localparam int W = 640;
    localparam int MP[4] = '{64, 10, 20, 32};
    localparam int SP[4] = '{32, 10, 8, 40};
    logic clock_i = 1'b0, rst_b_i = 1'b0, sfr_wr_i = 1'b0, ext_osc_settled_i = 1'b0;
    logic int_osc_i = 1'b0, ext_osc_i = 1'b0, rtc_osc_i = 1'b0;
    logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, sfr_rdata_o, d, r;
    logic [2:0] ext_osc_mode_i = '0;
    logic system_clock_o, clock_out_pin_o, ext_timer_clk_o, mult_clock_o, crystal_valid_o, mult_locked_o;
    logic [3:0] p = '0;
    int n_mismatch = 0, cmp_count = 0, oc = 0, c_sys, c_pin, c_tmr, c_mul;
    cms_clock_ctrl i_cms_clock_ctrl (.clock_i(clock_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o), .int_osc_i(int_osc_i),
        .ext_osc_i(ext_osc_i), .rtc_osc_i(rtc_osc_i), .ext_osc_settled_i(ext_osc_settled_i),
        .ext_osc_mode_i(ext_osc_mode_i), .system_clock_o(system_clock_o), .clock_out_pin_o(clock_out_pin_o),
        .ext_timer_clk_o(ext_timer_clk_o), .mult_clock_o(mult_clock_o), .crystal_valid_o(crystal_valid_o),
        .mult_locked_o(mult_locked_o));
    // System clock of 8 ns.
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    // Oscillators of 32, 10 and 40 cycles, every 40-cycle edge falling on a 10-cycle edge, and rise counters.
    always @(posedge clock_i) begin
        oc <= oc + 1;
        if (oc % 16 == 15) int_osc_i <= ~int_osc_i;
        if (oc % 5 == 2) ext_osc_i <= ~ext_osc_i;
        if (oc % 20 == 7) rtc_osc_i <= ~rtc_osc_i;
        c_sys = c_sys + int'(system_clock_o && !p[3]);
        c_pin = c_pin + int'(clock_out_pin_o && !p[2]);
        c_tmr = c_tmr + int'(ext_timer_clk_o && !p[1]);
        c_mul = c_mul + int'(mult_clock_o && !p[0]);
        p <= {system_clock_o, clock_out_pin_o, ext_timer_clk_o, mult_clock_o};
    end
    // Compares and counts; an unknown never matches.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Edge counts jitter by the synchroniser phase, so a small tolerance is allowed.
    function automatic logic near(input int a, input int b, input int t);
        return (a >= b - t) && (a <= b + t);
    endfunction : near
    // Scale 1 gives four output periods per input period; a divisor of N gives eight half ticks over N.
    function automatic int mul_rises(input int per, input int n);
        return W / per * 8 / n;
    endfunction : mul_rises
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= v;
        sfr_wr_i <= 1'b1;
        @(posedge clock_i);
        sfr_wr_i <= 1'b0;
    endtask : wr
    // Read data is registered, so it is taken one edge after the address.
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        sfr_addr_i <= a;
        @(posedge clock_i);
        #1 r = sfr_rdata_o;
    endtask : rd
    task automatic window();
        @(posedge clock_i);
        #1 c_sys = 0;
        c_pin = 0;
        c_tmr = 0;
        c_mul = 0;
        repeat (W) @(posedge clock_i);
        #1;
    endtask : window
    // Full bring-up: clear, select and scale, enable, wait over 5 us, initialize, poll ready.
    task automatic bring(input logic [1:0] s, input logic [2:0] k);
        wr(ADDR_MULT_CTRL, 8'h00);
        wr(ADDR_MULT_CTRL, {3'h4, k, s});
        rd(ADDR_MULT_CTRL);
        check(r, {3'h4, k, s});
        repeat (700) @(posedge clock_i);
        wr(ADDR_MULT_CTRL, {3'h6, k, s});
        rd(ADDR_MULT_CTRL);
        for (int i = 0; i < 300 && r[5] !== 1'b1; i++) rd(ADDR_MULT_CTRL);
        check(r, {3'h7, k, s});
        check(mult_locked_o, 1'b1);
    endtask : bring
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // A hang is cut off well past the roughly 24000 cycles the sequence needs.
    initial begin
        repeat (60000) @(posedge clock_i);
        n_mismatch++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        void'($urandom(71506));
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(ADDR_SYSTEM_CLOCK_SEL);
        check(r, REG_RESET);
        rd(ADDR_MULT_CTRL);
        check(r, REG_RESET);
        // Random bytes; the reserved select bit is kept clear as software must.
        repeat (8) begin
            d = 8'($urandom);
            wr(ADDR_SYSTEM_CLOCK_SEL, d & 8'hfb);
            rd(ADDR_SYSTEM_CLOCK_SEL);
            check(r, d & SC_STORE_MASK);
            wr(ADDR_MULT_CTRL, d & 8'h7f);
            rd(ADDR_MULT_CTRL);
            check(r, d & 8'h1f);
            wr(8'haa, d);
            rd(8'haa);
            check(r, 8'h00);
        end
        wr(ADDR_MULT_CTRL, 8'hc3);
        rd(ADDR_MULT_CTRL);
        check(r, 8'h83);
        // The settled level stands in for crystal start-up, so the long wait shrinks to a few cycles.
        for (int m = 0; m < 16; m++) begin
            @(posedge clock_i);
            ext_osc_mode_i <= m[2:0];
            ext_osc_settled_i <= m[3];
            repeat (8) @(posedge clock_i);
            #1 check(crystal_valid_o, m[3] && m[2:1] == 2'h3);
        end
        for (int s = 0; s < 4; s++) begin
            // The external oscillator runs and reads settled before any bring-up from it.
            bring(s[1:0], 3'h0);
            window();
            check(near(c_mul, mul_rises(MP[s], 2), 3), 1'b1);
        end
        for (int k = 7; k >= 0; k--) begin
            // Four times the internal oscillator stays well below the system clock limit.
            bring(2'h3, k[2:0]);
            window();
            check(near(c_mul, mul_rises(MP[3], k < 3 ? 2 : k), 3), 1'b1);
        end
        // Every source in turn, switched while running.
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_SYSTEM_CLOCK_SEL, {6'h0, s[1:0]});
            repeat (200) @(posedge clock_i);
            window();
            check(near(c_sys, W / SP[s], 2), 1'b1);
            check(near(c_pin, W / SP[s], 2), 1'b1);
            check(near(c_tmr, W / 10, 2), 1'b1);
        end
        for (int v = 0; v < 4; v++) begin
            wr(ADDR_SYSTEM_CLOCK_SEL, {2'h0, v[1:0], 4'h2});
            repeat (50) @(posedge clock_i);
            window();
            check(near(c_pin, (W / 8) >> v, 1), 1'b1);
        end
        wr(ADDR_MULT_CTRL, 8'h03);
        repeat (2) @(posedge clock_i);
        #1 check(mult_locked_o, 1'b0);
        report_and_stop();
    end
endmodule : clock_multiplier_system_clock_select_tb
`default_nettype wire
